/* rtl/spfc_pkg.sv */
/*
 * Shared constants and types for the shared pin function control block.
 * Assumes an 8-bit register port with eight byte-wide registers.
 */
package spfc_pkg;
    // Widths.
    localparam int DW = 8;
    localparam int AW = 3;
    localparam int NPIN = 6;
    localparam int NKEY = 4;
    localparam int CW = 4;

    // Register addresses.
    localparam logic [AW-1:0] ADDR_OPT = 3'h0;
    localparam logic [AW-1:0] ADDR_FRC = 3'h1;
    localparam logic [AW-1:0] ADDR_PUE = 3'h2;
    localparam logic [AW-1:0] ADDR_SLEW = 3'h3;
    localparam logic [AW-1:0] ADDR_DRV = 3'h4;
    localparam logic [AW-1:0] ADDR_KPE = 3'h5;
    localparam logic [AW-1:0] ADDR_KES = 3'h6;
    localparam logic [AW-1:0] ADDR_STAT = 3'h7;

    // Bit positions in system_options_one.
    localparam int OPT_RST_EN = 0;
    localparam int OPT_DBG_EN = 1;
    localparam int OPT_IRQ_EN = 2;
    localparam int OPT_IRQ_PDD = 3;
    localparam int OPT_IRQ_RISE = 4;
    localparam int OPT_TOP = 4;
    localparam logic [DW-1:0] OPT_RESET = 8'h02;

    // Bit of the debug force reset register.
    localparam int FRC_BIT = 0;

    // Bit positions in the status register.
    localparam int STAT_RST_FN = 0;
    localparam int STAT_ABM = 1;
    localparam int STAT_A5 = 2;
    localparam int STAT_SRC_PIN = 3;
    localparam int STAT_SRC_FRC = 4;

    // Pin numbers on port A.
    localparam int PIN_DBG = 4;
    localparam int PIN_SHARED = 5;

    // Clock rates and bus divider.
    localparam int INT_CLK_HZ = 16_000_000;
    localparam int BUS_CLK_HZ = 4_000_000;
    localparam int BUS_DIV = INT_CLK_HZ / BUS_CLK_HZ;
    localparam int BUS_DIV_W = 2;
    localparam logic [BUS_DIV_W-1:0] BUS_DIV_LAST = BUS_DIV_W'(BUS_DIV - 1);

    // Bus ticks that an internal reset lasts after its cause ends.
    localparam logic [CW-1:0] HOLD_TICKS = 4'h8;

    // Reset sequencer states.
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_RUN = 4'h2,
        ST_PINRST = 4'h4,
        ST_FORCE = 4'h8
    } spfc_state_t;

    // Function currently given to the shared pin.
    typedef struct packed {
        logic reset_fn;
        logic irq_fn;
        logic capture_fn;
        logic gpio_fn;
    } spfc_func_t;

    // Pad controls for port A.
    typedef struct packed {
        logic [NPIN-1:0] pull_en;
        logic [NPIN-1:0] pull_down;
        logic [NPIN-1:0] slew_en;
        logic [NPIN-1:0] drive_high;
    } spfc_pad_t;
endpackage : spfc_pkg

/* rtl/spfc_sync.sv */
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes idle-high pins, so each chain resets to one.
 */
`timescale 1ns/100ps
module spfc_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_chain
            logic meta;
            // First flop feeds only the second one.
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    meta <= 1'b1;
                    o_sync[g] <= 1'b1;
                end else begin
                    meta <= i_async[g];
                    o_sync[g] <= meta;
                end
            end
        end
    endgenerate
endmodule : spfc_sync

/* rtl/spfc_bus_div.sv */
/*
 * Bus clock divider making a one-cycle tick at the bus rate.
 * Assumes the reference clock stands for the internal clock source.
 */
`timescale 1ns/100ps
module spfc_bus_div (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Bus rate tick.
    output logic o_tick
);
    logic [spfc_pkg::BUS_DIV_W-1:0] cnt;

    // Counts the divide ratio and pulses on the last count.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt == spfc_pkg::BUS_DIV_LAST);
            if (cnt == spfc_pkg::BUS_DIV_LAST) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule : spfc_bus_div

/* rtl/spfc_top.sv */
/*
 * Shared pin function control: function of the shared reset-capable pin,
 * pad pull, slew and drive controls of port A, reset requests and mode entry.
 * Assumes i_ref_clk is the system bus clock, i_rst is the power-on reset,
 * and the core applies o_int_reset as its internal reset.
 */
// Behaviour
// - Power-on into user mode leaves the shared pin a port A input.
// - Reset-pin enable makes the pin reset input until next power-on.
// - Low level on the pin in reset function resets the device.
// - Reset-pin enable turns on the shared pin pullup automatically.
// - Power-on into background mode makes the shared pin the reset input.
// - Timer two capture mode routes the pin to its capture input.
// - Interrupt-pin enable gives a pull device; software picks its direction.
// - Port A bit 4 pullup is on while debug pin enable is set.
// - Keypad edge select turns an enabled keypad pullup into pulldown.
// - All registers run on the system bus clock.
// - Out of reset the bus runs at a quarter of the internal clock.
// - Background mode only from mode pin low at power-on or force reset.
// - Pullups on inputs, bits 4 and 5 also by function; slew and drive per pin on outputs.
// - Pullup is forced off while any driver uses the pin as output, except bit 4 under debug enable and bit 5 in reset or interrupt function.
// - Every reset sets debug pin enable; software clears it.
`timescale 1ns/100ps
module spfc_top (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port.
    input wire logic [spfc_pkg::AW-1:0] i_addr,
    input wire logic [spfc_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [spfc_pkg::DW-1:0] o_rdata,
    // Pins and pin usage.
    input wire logic i_port_a_bit5,
    input wire logic i_port_a_bit4,
    input wire logic [spfc_pkg::NPIN-1:0] i_port_dir_out,
    input wire logic [spfc_pkg::NPIN-1:0] i_periph_out,
    input wire logic i_timer_two_capture_mode,
    // Routed shared pin levels.
    output logic o_port_a_bit5,
    output logic o_ext_interrupt_in,
    output logic o_timer_two_capture_input,
    output spfc_pkg::spfc_func_t o_func,
    // Pad controls.
    output spfc_pkg::spfc_pad_t o_pad,
    // Reset and mode.
    output logic o_int_reset,
    output logic o_active_background_state,
    output logic o_bus_tick
);
    typedef struct packed {
        spfc_pkg::spfc_state_t fsm;
        logic [spfc_pkg::CW-1:0] cnt;
        logic [spfc_pkg::DW-1:0] opt;
        logic [spfc_pkg::NPIN-1:0] pue;
        logic [spfc_pkg::NPIN-1:0] slew;
        logic [spfc_pkg::NPIN-1:0] drv;
        logic [spfc_pkg::NKEY-1:0] kpe;
        logic [spfc_pkg::NKEY-1:0] kes;
        logic abm;
        logic src_pin;
        logic src_frc;
        logic [spfc_pkg::DW-1:0] rdata;
        logic int_rst;
        logic tick;
        spfc_pkg::spfc_func_t func;
        spfc_pkg::spfc_pad_t pad;
        logic a5_lvl;
        logic irq_in;
        logic cap_in;
    } spfc_st_t;

    spfc_st_t s;
    spfc_st_t next_s;
    logic [1:0] pin_sync;
    logic tick;
    logic a5_sync;
    logic a4_sync;

    // Synchronises the shared pin and the mode select pin.
    // reset pin synchroniser
    spfc_sync #(
        .W(2)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({i_port_a_bit5, i_port_a_bit4}),
        .o_sync(pin_sync)
    );

    // Bus rate tick paces the reset sequencer.
    // default bus divider
    spfc_bus_div u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    assign a5_sync = pin_sync[1];
    assign a4_sync = pin_sync[0];

    // Restores software settings on any reset; the sticky enable takes keep_rst.
    function automatic spfc_st_t apply_reset(input spfc_st_t v, input logic keep_rst);
        spfc_st_t r;
        r = v;
        r.opt = spfc_pkg::OPT_RESET;
        r.opt[spfc_pkg::OPT_RST_EN] = keep_rst;
        r.pue = '0;
        r.slew = '0;
        r.drv = '0;
        r.kpe = '0;
        r.kes = '0;
        r.cnt = '0;
        return r;
    endfunction : apply_reset

    // Next state: bus access, reset sequencer and pin routing.
    always_comb begin
        next_s = s;
        next_s.rdata = '0;
        next_s.tick = tick;

        if (i_wr && (s.fsm == spfc_pkg::ST_RUN)) begin
            if (i_addr == spfc_pkg::ADDR_OPT) begin
                next_s.opt = {3'h0, i_wdata[spfc_pkg::OPT_TOP:0]};
                next_s.opt[spfc_pkg::OPT_RST_EN] =
                    s.opt[spfc_pkg::OPT_RST_EN] | i_wdata[spfc_pkg::OPT_RST_EN];
            end else if (i_addr == spfc_pkg::ADDR_FRC) begin
                if (i_wdata[spfc_pkg::FRC_BIT]) begin
                    // Built on next_s so the bus tick and read data keep their pace.
                    next_s = apply_reset(next_s, s.opt[spfc_pkg::OPT_RST_EN]);
                    next_s.fsm = spfc_pkg::ST_FORCE;
                end
            end else if (i_addr == spfc_pkg::ADDR_PUE) begin
                next_s.pue = i_wdata[spfc_pkg::NPIN-1:0];
            end else if (i_addr == spfc_pkg::ADDR_SLEW) begin
                next_s.slew = i_wdata[spfc_pkg::NPIN-1:0];
            end else if (i_addr == spfc_pkg::ADDR_DRV) begin
                next_s.drv = i_wdata[spfc_pkg::NPIN-1:0];
            end else if (i_addr == spfc_pkg::ADDR_KPE) begin
                next_s.kpe = i_wdata[spfc_pkg::NKEY-1:0];
            end else if (i_addr == spfc_pkg::ADDR_KES) begin
                next_s.kes = i_wdata[spfc_pkg::NKEY-1:0];
            end
        end

        // Read data stand for one cycle after the strobe.
        if (i_rd) begin
            if (i_addr == spfc_pkg::ADDR_OPT) begin
                next_s.rdata = s.opt;
            end else if (i_addr == spfc_pkg::ADDR_PUE) begin
                next_s.rdata = {2'h0, s.pue};
            end else if (i_addr == spfc_pkg::ADDR_SLEW) begin
                next_s.rdata = {2'h0, s.slew};
            end else if (i_addr == spfc_pkg::ADDR_DRV) begin
                next_s.rdata = {2'h0, s.drv};
            end else if (i_addr == spfc_pkg::ADDR_KPE) begin
                next_s.rdata = {4'h0, s.kpe};
            end else if (i_addr == spfc_pkg::ADDR_KES) begin
                next_s.rdata = {4'h0, s.kes};
            end else if (i_addr == spfc_pkg::ADDR_STAT) begin
                next_s.rdata[spfc_pkg::STAT_RST_FN] = s.func.reset_fn;
                next_s.rdata[spfc_pkg::STAT_ABM] = s.abm;
                next_s.rdata[spfc_pkg::STAT_A5] = s.a5_lvl;
                next_s.rdata[spfc_pkg::STAT_SRC_PIN] = s.src_pin;
                next_s.rdata[spfc_pkg::STAT_SRC_FRC] = s.src_frc;
            end
        end

        // Reset sequencer.
        case (s.fsm)
            spfc_pkg::ST_POR: begin
                if (tick) begin
                    next_s.cnt = s.cnt + 4'h1;
                end
                if (s.cnt == spfc_pkg::HOLD_TICKS) begin
                    next_s.fsm = spfc_pkg::ST_RUN;
                    next_s.cnt = '0;
                    next_s.abm = ~a4_sync;
                    next_s.opt[spfc_pkg::OPT_RST_EN] = ~a4_sync;
                end
            end
            spfc_pkg::ST_RUN: begin
                if (s.func.reset_fn && !a5_sync) begin
                    next_s = apply_reset(next_s, 1'b1);
                    next_s.fsm = spfc_pkg::ST_PINRST;
                end
            end
            spfc_pkg::ST_PINRST: begin
                if (!a5_sync) begin
                    next_s.cnt = '0;
                end else if (tick) begin
                    next_s.cnt = s.cnt + 4'h1;
                end
                if (a5_sync && (s.cnt == spfc_pkg::HOLD_TICKS)) begin
                    next_s.fsm = spfc_pkg::ST_RUN;
                    next_s.cnt = '0;
                    next_s.src_pin = 1'b1;
                    next_s.src_frc = 1'b0;
                    next_s.abm = 1'b0;
                end
            end
            spfc_pkg::ST_FORCE: begin
                if (tick) begin
                    next_s.cnt = s.cnt + 4'h1;
                end
                if (s.cnt == spfc_pkg::HOLD_TICKS) begin
                    next_s.fsm = spfc_pkg::ST_RUN;
                    next_s.cnt = '0;
                    next_s.src_pin = 1'b0;
                    next_s.src_frc = 1'b1;
                    next_s.abm = ~a4_sync;
                end
            end
            default: begin
                next_s.fsm = spfc_pkg::ST_POR;
                next_s.cnt = '0;
            end
        endcase

        next_s.int_rst = (next_s.fsm != spfc_pkg::ST_RUN);

        // Shared pin function, highest priority first.
        // reset function while enabled
        next_s.func.reset_fn = next_s.opt[spfc_pkg::OPT_RST_EN];
        next_s.func.irq_fn = ~next_s.func.reset_fn & next_s.opt[spfc_pkg::OPT_IRQ_EN];
        next_s.func.capture_fn = ~next_s.func.reset_fn & ~next_s.func.irq_fn
            & i_timer_two_capture_mode;
        next_s.func.gpio_fn = ~next_s.func.reset_fn & ~next_s.func.irq_fn
            & ~next_s.func.capture_fn;
        next_s.a5_lvl = a5_sync;
        next_s.irq_in = next_s.func.irq_fn ? a5_sync : 1'b1;
        next_s.cap_in = next_s.func.capture_fn & a5_sync;

        // Pad controls for each port A pin.
        for (int i = 0; i < spfc_pkg::NPIN; i++) begin
            next_s.pad.pull_en[i] = 1'b0;
            next_s.pad.pull_down[i] = 1'b0;
            if (!(i_port_dir_out[i] | i_periph_out[i])) begin
                next_s.pad.pull_en[i] = next_s.pue[i];
            end
            next_s.pad.slew_en[i] = next_s.slew[i] & (i_port_dir_out[i] | i_periph_out[i]);
            next_s.pad.drive_high[i] = next_s.drv[i] & (i_port_dir_out[i] | i_periph_out[i]);
        end
        for (int k = 0; k < spfc_pkg::NKEY; k++) begin
            next_s.pad.pull_down[k] = next_s.kpe[k] & next_s.kes[k] & next_s.pad.pull_en[k];
        end
        if (next_s.opt[spfc_pkg::OPT_DBG_EN]) begin
            next_s.pad.pull_en[spfc_pkg::PIN_DBG] = 1'b1;
            next_s.pad.pull_down[spfc_pkg::PIN_DBG] = 1'b0;
        end
        if (next_s.func.irq_fn) begin
            next_s.pad.pull_en[spfc_pkg::PIN_SHARED] = ~next_s.opt[spfc_pkg::OPT_IRQ_PDD];
            next_s.pad.pull_down[spfc_pkg::PIN_SHARED] = next_s.opt[spfc_pkg::OPT_IRQ_RISE];
        end
        if (next_s.func.reset_fn) begin
            next_s.pad.pull_en[spfc_pkg::PIN_SHARED] = 1'b1;
            next_s.pad.pull_down[spfc_pkg::PIN_SHARED] = 1'b0;
        end

        // Power-on reset values.
        if (i_rst) begin
            next_s = '0;
            next_s = apply_reset(next_s, 1'b0);
            next_s.fsm = spfc_pkg::ST_POR;
            next_s.int_rst = 1'b1;
            next_s.irq_in = 1'b1;
            next_s.a5_lvl = 1'b1;
            next_s.func.gpio_fn = 1'b1;
            next_s.pad.pull_en[spfc_pkg::PIN_DBG] = 1'b1;
        end
    end

    // Registers the whole state on the system bus clock.
    // single bus clock domain
    always_ff @(posedge i_ref_clk) begin
        s <= next_s;
    end

    // Outputs straight from the state flops.
    assign o_rdata = s.rdata;
    assign o_port_a_bit5 = s.a5_lvl;
    assign o_ext_interrupt_in = s.irq_in;
    assign o_timer_two_capture_input = s.cap_in;
    assign o_func = s.func;
    assign o_pad = s.pad;
    assign o_int_reset = s.int_rst;
    assign o_active_background_state = s.abm;
    assign o_bus_tick = s.tick;
endmodule : spfc_top

/* sim/spfc_top_assertions.sv */
/*
 * Port checks for the shared pin function block.
 * Assumes one clock domain and a synchronous active-high power-on reset.
 */
`timescale 1ns/100ps
module spfc_top_assertions (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port and pin inputs.
    input wire logic [spfc_pkg::AW-1:0] i_addr,
    input wire logic [spfc_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_port_a_bit5,
    input wire logic [spfc_pkg::NPIN-1:0] i_port_dir_out,
    input wire logic [spfc_pkg::NPIN-1:0] i_periph_out,
    // Outputs under check.
    input wire logic [spfc_pkg::DW-1:0] o_rdata,
    input wire logic o_ext_interrupt_in,
    input wire logic o_timer_two_capture_input,
    input wire spfc_pkg::spfc_func_t o_func,
    input wire spfc_pkg::spfc_pad_t o_pad,
    input wire logic o_int_reset,
    input wire logic o_active_background_state,
    input wire logic o_bus_tick
);
    // Every check runs on the bus clock and sleeps in power-on reset.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    bus_tick_period_a:
    assert property (o_bus_tick |=> !o_bus_tick [*3] ##1 o_bus_tick)
        else $error("bus tick spacing wrong");
    read_data_idle_a:
    assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    func_one_hot_a:
    assert property ($onehot(o_func))
        else $error("shared pin function not one-hot");
    reset_fn_sticky_a:
    assert property (o_func.reset_fn |=> o_func.reset_fn)
        else $error("reset function dropped");
    pin_reset_latency_a:
    assert property (o_func.reset_fn && !o_int_reset && $fell(i_port_a_bit5)
        |-> ##[1:4] o_int_reset)
        else $error("pin low gave no reset");
    pin_sync_delay_a:
    assert property ($fell(i_port_a_bit5) && !o_int_reset && !i_wr |=> !o_int_reset)
        else $error("pin reset not synchronised");
    reset_pullup_on_a:
    assert property (o_func.reset_fn && $past(o_func.reset_fn)
        |-> o_pad.pull_en[5] && !o_pad.pull_down[5])
        else $error("reset pin pullup missing");
    gpio_route_idle_a:
    assert property (o_func.gpio_fn && $past(o_func.gpio_fn) && $past(o_func.gpio_fn, 2)
        |-> !o_timer_two_capture_input && o_ext_interrupt_in)
        else $error("idle route not at rest");
    out_pull_off_a:
    assert property (1'b1 |=>
        (o_pad.pull_en[3:0] & $past(i_port_dir_out[3:0] | i_periph_out[3:0])) == 4'h0)
        else $error("pullup on an output");
    out_only_slew_a:
    assert property (1'b1 |=> ((o_pad.slew_en | o_pad.drive_high)
        & ~$past(i_port_dir_out | i_periph_out)) == 6'h00)
        else $error("slew or drive on an input");
    force_reset_hold_a:
    assert property (i_wr && i_addr == spfc_pkg::ADDR_FRC
        && i_wdata[spfc_pkg::FRC_BIT] && !o_int_reset |=> o_int_reset [*8])
        else $error("force reset too short");
    background_entry_a:
    assert property ($rose(o_active_background_state) |-> o_int_reset || $past(o_int_reset))
        else $error("background entered outside reset");

    // Main scenarios seen.
    cover property ($rose(o_active_background_state));
    cover property (o_func.reset_fn && $rose(o_int_reset));
    cover property (o_func.irq_fn && !o_ext_interrupt_in);
    cover property (o_func.capture_fn);
endmodule : spfc_top_assertions

bind spfc_top spfc_top_assertions u_chk (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_port_a_bit5, .i_port_dir_out, .i_periph_out, .o_rdata, .o_ext_interrupt_in,
    .o_timer_two_capture_input, .o_func, .o_pad, .o_int_reset, .o_active_background_state,
    .o_bus_tick);

/* sim/spfc_pod.sv */
/*
 * Board side of the shared pins: external reset source and debug pod.
 * Assumes both pins carry pull-ups, so a released pin reads high.
 */
`timescale 1ns/100ps
module spfc_pod (
    // Clock.
    input wire logic i_ref_clk,
    // Requests from the bench.
    input wire logic i_shared_low,
    input wire logic i_mode_low,
    input wire logic i_slow,
    // Pin levels.
    output logic o_shared_pin,
    output logic o_mode_pin
);
    logic [1:0] lag = 2'b00;

    // A slow source lags its reset request by two cycles.
    always_ff @(posedge i_ref_clk) begin
        lag <= {lag[0], i_shared_low};
    end

    // drive reset low
    // Released, the pin returns to its pull-up level.
    assign o_shared_pin = !(i_slow ? lag[1] : i_shared_low);
    assign o_mode_pin = !i_mode_low;
endmodule : spfc_pod

/* sim/spfc_top_tb_top.sv */
/*
 * Self-checking bench for the shared pin function block with a register model.
 * Assumes the pod model stands on the pins and the checker is bound in.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module spfc_top_tb_top;
    // Design inputs and pod requests.
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] dir = 6'h00;
    logic [5:0] per = 6'h00;
    logic tmode = 1'b0;
    logic rlow = 1'b0;
    logic mlow = 1'b0;
    logic slow = 1'b0;
    // Design outputs and pin levels.
    logic pin5, pin4, a5, eint, cap, irst, abm_o, tick;
    logic [7:0] rdata;
    spfc_pkg::spfc_func_t func;
    spfc_pkg::spfc_pad_t pad;
    // Register model, counters and random state.
    int opt, pue, slw, drv, kpe, kes, abm, bypin, frc, k;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 74;
    int modes [6] = '{8'h00, 8'h02, 8'h04, 8'h14, 8'h0c, 8'h06};

    // Bus clock of 100 ns.
    always #50 i_ref_clk = ~i_ref_clk;

    spfc_pod pod (.i_ref_clk(i_ref_clk), .i_shared_low(rlow), .i_mode_low(mlow),
        .i_slow(slow), .o_shared_pin(pin5), .o_mode_pin(pin4));
    spfc_top dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port_a_bit5(pin5), .i_port_a_bit4(pin4),
        .i_port_dir_out(dir), .i_periph_out(per), .i_timer_two_capture_mode(tmode),
        .o_port_a_bit5(a5), .o_ext_interrupt_in(eint), .o_timer_two_capture_input(cap),
        .o_func(func), .o_pad(pad), .o_int_reset(irst), .o_active_background_state(abm_o),
        .o_bus_tick(tick));

    // Cuts a hung run short.
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic reg_write(input logic [2:0] a, input int d);
        @(posedge i_ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= 8'(d);
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [2:0] a, input int e);
        @(posedge i_ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 8'(e))
    endtask : reg_read

    // Waits, bounded, until the internal reset has ended.
    task automatic wait_run();
        int n;
        n = 0;
        repeat (2) @(posedge i_ref_clk);
        while (irst !== 1'b0 && n < 300) begin
            @(posedge i_ref_clk);
            n++;
        end
        if (n >= 300) bad_count++;
    endtask : wait_run

    // Model state after any reset.
    task automatic mdl(input int o1, input int ab, input int bp, input int fr);
        opt = 2 + o1;
        pue = 0;
        slw = 0;
        drv = 0;
        kpe = 0;
        kes = 0;
        abm = ab;
        bypin = bp;
        frc = fr;
    endtask : mdl

    task automatic por(input logic ms);
        @(posedge i_ref_clk);
        mlow <= ms;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        wait_run();
        mlow <= 1'b0;
        mdl(ms, ms, 0, 0);
    endtask : por

    function automatic spfc_pkg::spfc_pad_t exp_pad();
        spfc_pkg::spfc_pad_t p;
        logic [5:0] o;
        o = dir | per;
        p.pull_en = 6'(pue) & ~o;
        p.pull_down = 6'(kpe & kes) & p.pull_en & 6'h0f;
        p.slew_en = 6'(slw) & o;
        p.drive_high = 6'(drv) & o;
        if (opt[1]) p.pull_en[4] = 1'b1;
        if (opt[0]) begin
            p.pull_en[5] = 1'b1;
        end else if (opt[2]) begin
            p.pull_en[5] = !opt[3];
            p.pull_down[5] = opt[4];
        end
        return p;
    endfunction : exp_pad

    // Compares every result against the model once the pins have settled.
    task automatic check_all();
        logic c;
        logic q;
        logic [2:0] n;
        n = 3'h0;
        // Exactly one bus tick falls in any four clocks.
        repeat (4) begin
            @(posedge i_ref_clk);
            #1;
            n = n + {2'b00, tick};
        end
        @(posedge i_ref_clk);
        #1;
        // Taken after the wait, so inputs set just before the call count.
        c = !opt[0] && !opt[2] && tmode;
        q = !opt[0] && opt[2];
        `CHK(n, 3'h1)
        `CHK(pad, exp_pad())
        `CHK(func, {opt[0] == 1, q, c, !opt[0] && !opt[2] && !tmode})
        `CHK(a5, !rlow)
        `CHK(eint, q ? !rlow : 1'b1)
        `CHK(cap, c ? !rlow : 1'b0)
        `CHK(abm_o, abm[0])
        reg_read(3'h0, opt);
        reg_read(3'h7, frc * 16 + bypin * 8 + (rlow ? 0 : 4) + abm * 2 + opt[0]);
    endtask : check_all

    // Main sequence.
    initial begin
        por(1'b0);
        check_all();
        for (k = 0; k < 6; k++) begin
            pue = $random(seed) & 8'h3f;
            slw = $random(seed) & 8'h3f;
            drv = $random(seed) & 8'h3f;
            kpe = $random(seed) & 8'h0f;
            kes = $random(seed) & 8'h0f;
            reg_write(3'h2, pue);
            reg_write(3'h3, slw);
            reg_write(3'h4, drv);
            reg_write(3'h5, kpe);
            reg_write(3'h6, kes);
            opt = modes[k];
            reg_write(3'h0, opt);
            @(posedge i_ref_clk);
            dir <= 6'($random(seed));
            per <= 6'($random(seed));
            tmode <= 1'($random(seed));
            rlow <= 1'($random(seed));
            check_all();
        end
        rlow <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        opt = 1;
        reg_write(3'h0, 1);
        reg_write(3'h0, 0);
        check_all();
        slow <= 1'b1;
        rlow <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        #1;
        `CHK(irst, 1'b1)
        @(posedge i_ref_clk);
        rlow <= 1'b0;
        wait_run();
        mdl(1, 0, 1, 0);
        check_all();
        mlow <= 1'b1;
        reg_write(3'h1, 1);
        wait_run();
        mdl(1, 1, 0, 1);
        check_all();
        mlow <= 1'b0;
        por(1'b1);
        check_all();
        por(1'b0);
        check_all();
        complete_run();
    end
endmodule : spfc_top_tb_top
